// ===== hw/mjump_pkg.sv
package mjump_pkg;
    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int PC_W = 10;
    localparam int INSTR_W = 16;
    localparam int OFFS_W = 5;
    localparam int COND_W = 6;
    localparam int FBK_W = 4;
    localparam int NUM_FLAGS = 16;
    localparam int NUM_TC = 4;
    localparam int NUM_SC = 3;
    localparam int NUM_CUR = 3;
    localparam int NUM_FBK = 16;
    localparam int NUM_COND = 64;

    // ----------------------------------------
    // Opcode patterns and field positions
    // ----------------------------------------
    localparam logic [10:0] OPC_JREL = 11'h178;
    localparam logic [11:0] OPC_JABS = 12'h39a;
    localparam logic [2:0] OPC_JABS_LOW = 3'h5;
    localparam logic [4:0] OPC_CABS = 5'h07;
    localparam logic [2:0] OPC_CABS_LOW = 3'h0;
    localparam logic [4:0] OPC_CREL = 5'h00;
    localparam logic [5:0] OPC_FREL = 6'h05;
    localparam int CABS_COND_LSB = 4;
    localparam int CREL_COND_LSB = 5;
    localparam int FREL_FBK_LSB = 5;
    localparam int FREL_POL_BIT = 9;
    localparam int JREG_SEL_BIT = 3;

    // ----------------------------------------
    // Condition selector codes
    // ----------------------------------------
    localparam int C_FLAG_LO = 0;
    localparam int C_FLAG_HI = 16;
    localparam int C_FLAG12 = 12;
    localparam int C_TC = 32;
    localparam int C_START_LO = 36;
    localparam int C_START_HI = 37;
    localparam int C_SCV_LO = 38;
    localparam int C_SCS_LO = 41;
    localparam int C_SCV_HI = 44;
    localparam int C_ALU_DONE = 47;
    localparam int C_BOOST_HI = 48;
    localparam int C_BOOST_LO = 49;
    localparam int C_CUR_HI = 50;
    localparam int C_CUR56_HI = 53;
    localparam int C_CUR_LO = 56;
    localparam int C_CUR56_LO = 59;
    localparam int C_OWN_HI = 62;
    localparam int C_OWN_LO = 63;

    localparam logic [PC_W-1:0] PC_STEP = 10'h001;
    localparam logic [PC_W-1:0] PC_RESET = 10'h000;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic start;
        logic boost_voltage_high;
        logic [NUM_SC-1:0] shortcut_drain;
        logic [NUM_SC-1:0] shortcut_source;
        logic [NUM_CUR-1:0] cur_fb;
        logic [NUM_CUR-1:0] cur5_fb;
        logic [NUM_CUR-1:0] cur6_fb;
        logic current_channel_four_high;
        logic own_cur_fb;
        logic [NUM_FBK-1:0] predriver_fb;
    } mjump_pin_s;

    typedef struct packed {
        logic valid;
        logic is_jump;
        logic taken;
        logic [PC_W-1:0] program_counter;
    } mjump_res_s;
endpackage

// ===== hw/mjump_unit.sv
`timescale 1ns/100ps
// What this block does
// - Unconditional relative jump: address plus offset
// - Offset five bits two's complement, -16..15
// - Unconditional absolute jump via selected jump register
// - Relative jump opcode in bits 15..5
// - Conditional absolute jump to register when true
// - Conditional absolute decode, selector in bits 9..4
// - Conditional relative jump adds offset when true
// - Config picks channel five or six
// - Channel four testable only when enabled
// - Enabled channel four replaces flag twelve
// - Flags low/high and terminal counts selectable
// - Condition for finished ALU request
// - Shortcut drain low/high, source low conditions
// - Start, boost, current feedback conditions
// - Own current feedback high or low
// - Relative jump on predriver feedback
// - Polarity bit picks active level
module mjump_unit (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Instruction from code RAM
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    input wire logic [9:0] instr_addr,
    // Jump registers
    input wire logic [9:0] jump_target_reg_a,
    input wire logic [9:0] jump_target_reg_b,
    // Same-clock condition sources
    input wire logic [15:0] flags,
    input wire logic [3:0] terminal_count,
    input wire logic alu_done,
    // Pin condition sources, asynchronous
    input wire mjump_pkg::mjump_pin_s pin_cond,
    // Configuration
    input wire logic current_channel_select_config,
    input wire logic current_channel_four_high_enable,
    // Result towards the program counter
    output mjump_pkg::mjump_res_s result
);

    // ----------------------------------------
    // Pin synchroniser
    // ----------------------------------------
    mjump_pkg::mjump_pin_s pin_meta_r;
    mjump_pkg::mjump_pin_s pin_sync_r;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end else begin
            pin_meta_r <= pin_cond;
            pin_sync_r <= pin_meta_r;
        end
    end

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire logic dec_jrel;
    wire logic dec_jabs;
    wire logic dec_cabs;
    wire logic dec_crel;
    wire logic dec_frel;

    assign dec_jrel = (instr[15:5] == mjump_pkg::OPC_JREL);
    assign dec_jabs = (instr[15:4] == mjump_pkg::OPC_JABS)
        && (instr[2:0] == mjump_pkg::OPC_JABS_LOW);
    assign dec_cabs = (instr[15:11] == mjump_pkg::OPC_CABS) && !instr[10]
        && (instr[2:0] == mjump_pkg::OPC_CABS_LOW) && !dec_jabs;
    assign dec_crel = (instr[15:11] == mjump_pkg::OPC_CREL);
    assign dec_frel = (instr[15:10] == mjump_pkg::OPC_FREL);

    // ----------------------------------------
    // Targets
    // ----------------------------------------
    wire logic [4:0] offset;
    wire logic [9:0] offset_ext;
    wire logic [9:0] rel_target;
    wire logic [9:0] seq_target;
    wire logic [9:0] reg_target;

    assign offset = instr[4:0];
    assign offset_ext = {{5{offset[4]}}, offset};
    assign rel_target = instr_addr + offset_ext;
    assign seq_target = instr_addr + mjump_pkg::PC_STEP;
    assign reg_target = instr[mjump_pkg::JREG_SEL_BIT] ? jump_target_reg_b
        : jump_target_reg_a;

    // ----------------------------------------
    // Condition vector
    // ----------------------------------------
    wire logic [63:0] cond_vec;
    wire logic [2:0] cur56_fb;
    wire logic [15:0] flag_eff;

    // One of channel five or six
    assign cur56_fb = current_channel_select_config ? pin_sync_r.cur6_fb
        : pin_sync_r.cur5_fb;

    genvar gi;
    generate
        for (gi = 0; gi < mjump_pkg::NUM_FLAGS; gi++) begin : g_flag
            if (gi == mjump_pkg::C_FLAG12) begin : g_f12
                assign flag_eff[gi] = current_channel_four_high_enable
                    ? pin_sync_r.current_channel_four_high : flags[gi];
            end else begin : g_fx
                assign flag_eff[gi] = flags[gi];
            end
            assign cond_vec[mjump_pkg::C_FLAG_LO + gi] = !flag_eff[gi];
            assign cond_vec[mjump_pkg::C_FLAG_HI + gi] = flag_eff[gi];
        end
        for (gi = 0; gi < mjump_pkg::NUM_TC; gi++) begin : g_tc
            assign cond_vec[mjump_pkg::C_TC + gi] = terminal_count[gi];
        end
        for (gi = 0; gi < mjump_pkg::NUM_SC; gi++) begin : g_sc
            assign cond_vec[mjump_pkg::C_SCV_LO + gi] = !pin_sync_r.shortcut_drain[gi];
            assign cond_vec[mjump_pkg::C_SCS_LO + gi] = !pin_sync_r.shortcut_source[gi];
            assign cond_vec[mjump_pkg::C_SCV_HI + gi] = pin_sync_r.shortcut_drain[gi];
        end
        for (gi = 0; gi < mjump_pkg::NUM_CUR; gi++) begin : g_cur
            assign cond_vec[mjump_pkg::C_CUR_HI + gi] = pin_sync_r.cur_fb[gi];
            assign cond_vec[mjump_pkg::C_CUR_LO + gi] = !pin_sync_r.cur_fb[gi];
            assign cond_vec[mjump_pkg::C_CUR56_HI + gi] = cur56_fb[gi];
            assign cond_vec[mjump_pkg::C_CUR56_LO + gi] = !cur56_fb[gi];
        end
    endgenerate

    assign cond_vec[mjump_pkg::C_START_LO] = !pin_sync_r.start;
    assign cond_vec[mjump_pkg::C_START_HI] = pin_sync_r.start;
    assign cond_vec[mjump_pkg::C_BOOST_HI] = pin_sync_r.boost_voltage_high;
    assign cond_vec[mjump_pkg::C_BOOST_LO] = !pin_sync_r.boost_voltage_high;
    assign cond_vec[mjump_pkg::C_ALU_DONE] = alu_done;
    assign cond_vec[mjump_pkg::C_OWN_HI] = pin_sync_r.own_cur_fb;
    assign cond_vec[mjump_pkg::C_OWN_LO] = !pin_sync_r.own_cur_fb;

    // ----------------------------------------
    // Condition select
    // ----------------------------------------
    wire logic [5:0] cabs_sel;
    wire logic [5:0] crel_sel;
    wire logic [3:0] fbk_sel;
    wire logic fbk_pol;
    wire logic cabs_true;
    wire logic crel_true;
    wire logic frel_true;

    assign cabs_sel = instr[mjump_pkg::CABS_COND_LSB +: mjump_pkg::COND_W];
    assign crel_sel = instr[mjump_pkg::CREL_COND_LSB +: mjump_pkg::COND_W];
    assign fbk_sel = instr[mjump_pkg::FREL_FBK_LSB +: mjump_pkg::FBK_W];
    assign fbk_pol = instr[mjump_pkg::FREL_POL_BIT];
    assign cabs_true = cond_vec[cabs_sel];
    assign crel_true = cond_vec[crel_sel];
    assign frel_true = (pin_sync_r.predriver_fb[fbk_sel] == fbk_pol);

    // ----------------------------------------
    // Next program counter
    // ----------------------------------------
    wire logic is_jump;
    wire logic taken;
    wire logic [9:0] pc_nxt;

    assign is_jump = dec_jrel || dec_jabs || dec_cabs || dec_crel || dec_frel;
    assign taken = dec_jrel || dec_jabs || (dec_cabs && cabs_true)
        || (dec_crel && crel_true) || (dec_frel && frel_true);
    assign pc_nxt = !taken ? seq_target
        : (dec_jabs || dec_cabs) ? reg_target : rel_target;

    // Counter, is_jump and taken held until next instruction; valid high for one cycle only
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            result <= '{valid: 1'b0, is_jump: 1'b0, taken: 1'b0,
                program_counter: mjump_pkg::PC_RESET};
        end else if (instr_valid) begin
            result <= '{valid: 1'b1, is_jump: is_jump, taken: taken,
                program_counter: pc_nxt};
        end else begin
            result.valid <= 1'b0;
        end
    end

endmodule

// ===== verification/mjump_checker_asserts.sv
`timescale 1ns/100ps
// ----------------------------------------
// Jump result checks
// ----------------------------------------
module mjump_checker (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Watched inputs
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    input wire logic [9:0] instr_addr,
    input wire logic [9:0] jump_target_reg_a,
    input wire logic [9:0] jump_target_reg_b,
    input wire logic [15:0] flags,
    input wire logic [3:0] terminal_count,
    input wire logic alu_done,
    // Result
    input wire mjump_pkg::mjump_res_s result
);
    wire logic [9:0] rel_tgt = instr_addr + {{5{instr[4]}}, instr[4:0]};
    wire logic [9:0] abs_tgt = instr[3] ? jump_target_reg_b : jump_target_reg_a;
    wire logic [9:0] seq_tgt = instr_addr + mjump_pkg::PC_STEP;
    wire logic is_jrel = instr_valid && instr[15:5] == mjump_pkg::OPC_JREL;
    wire logic is_jabs = instr_valid && instr[15:4] == mjump_pkg::OPC_JABS && instr[2:0] == 3'h5;
    wire logic is_crel = instr_valid && instr[15:11] == mjump_pkg::OPC_CREL;
    wire logic is_cabs = instr_valid && instr[15:10] == 6'h0e && instr[2:0] == 3'h0;
    wire logic flag_lo = !flags[instr[8:5]];
    wire logic flag_hi = flags[instr[7:4]];
    wire logic tc_hit = terminal_count[instr[6:5]];
    // Sum is only checked when taken; a not-taken answer is checked as a step
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    a_jrel_target: assert property (
        is_jrel |=> result.valid && result.taken && result.program_counter == $past(rel_tgt))
        else $error("relative jump target wrong");
    a_jabs_target: assert property (
        is_jabs |=> result.taken && result.program_counter == $past(abs_tgt))
        else $error("absolute jump target wrong");
    a_false_steps: assert property (
        result.valid && !result.taken |-> result.program_counter == $past(seq_tgt))
        else $error("not taken jump does not step");
    a_flag_low: assert property (
        is_crel && instr[10:9] == 2'h0 && instr[8:5] != 4'hc |=> result.taken == $past(flag_lo))
        else $error("flag low condition wrong");
    a_cabs_taken: assert property (
        is_cabs && instr[9:8] == 2'h1 && instr[7:4] != 4'hc |=> result.taken == $past(flag_hi)
        && (!result.taken || result.program_counter == $past(abs_tgt)))
        else $error("conditional absolute jump wrong");
    a_tc_cond: assert property (
        is_crel && instr[10:7] == 4'h8 |=> result.taken == $past(tc_hit)
        && (!result.taken || result.program_counter == $past(rel_tgt)))
        else $error("terminal count jump wrong");
    a_alu_cond: assert property (
        is_crel && instr[10:5] == 6'h2f |=> result.taken == $past(alu_done))
        else $error("alu done condition wrong");
    a_quiet_hold: assert property (
        !instr_valid |=> !result.valid && $stable(result.program_counter))
        else $error("result moved without instruction");
endmodule

bind mjump_unit mjump_checker i_chk (.clk_sys, .nrst, .instr_valid, .instr, .instr_addr,
    .jump_target_reg_a, .jump_target_reg_b, .flags, .terminal_count, .alu_done, .result);

// ===== verification/mjump_src.sv
`timescale 1ns/100ps
// ----------------------------------------
// Pin condition sources
// ----------------------------------------
module mjump_src (
    // Clock
    input wire logic clk_sys,
    // Requested and driven pin levels
    input wire mjump_pkg::mjump_pin_s want,
    output mjump_pkg::mjump_pin_s pin_cond
);
    // Pins move off the edge, unrelated to the core's sampling
    always @(posedge clk_sys) begin
        pin_cond <= #2 want;
    end
endmodule

// ===== verification/mjump_unit_test.sv
`timescale 1ns/100ps
// ----------------------------------------
// Jump unit bench
// ----------------------------------------
module mjump_unit_test;
    logic clk_sys = 1'h0;
    logic nrst = 1'h0;
    logic instr_valid = 1'h0;
    logic [15:0] instr = 16'h0000;
    logic [9:0] instr_addr = 10'h000;
    logic [9:0] jra = 10'h155;
    logic [9:0] jrb = 10'h2aa;
    logic [15:0] flags = 16'h0000;
    logic [3:0] tcnt = 4'h0;
    logic alu = 1'h0;
    logic cfg = 1'h0;
    logic c4 = 1'h0;
    mjump_pkg::mjump_pin_s want = '0;
    mjump_pkg::mjump_pin_s pin_cond;
    mjump_pkg::mjump_res_s result;
    int errors = 0;
    int comparisons = 0;
    int cyc = 0;
    always #4 clk_sys = ~clk_sys;
    mjump_src i_src (.clk_sys, .want, .pin_cond);
    mjump_unit i_dut (.clk_sys, .nrst, .instr_valid, .instr, .instr_addr,
        .jump_target_reg_a(jra), .jump_target_reg_b(jrb), .flags, .terminal_count(tcnt),
        .alu_done(alu), .pin_cond, .current_channel_select_config(cfg), .current_channel_four_high_enable(c4),
        .result);
    task automatic test_done();
        if (errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
        comparisons++;
        if (exp !== got) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One instruction, then a gap cycle so the strobe is never reassigned in one step
    task automatic run(input logic [15:0] ins, input logic [9:0] a, input logic tk,
        input logic [9:0] tgt, input logic jm = 1'h1);
        @(posedge clk_sys);
        instr_valid <= 1'h1;
        instr <= ins;
        instr_addr <= a;
        @(posedge clk_sys);
        instr_valid <= 1'h0;
        #1;
        chk("valid", 10'h001, {9'h000, result.valid});
        chk("is_jump", {9'h000, jm}, {9'h000, result.is_jump});
        chk("taken", {9'h000, tk}, {9'h000, result.taken});
        chk("pc", tk ? tgt : a + 10'h001, result.program_counter);
    endtask
    task automatic t_uncond();
        run(16'h2f0f, 10'h010, 1'h1, 10'h01f);
        run(16'h2f10, 10'h005, 1'h1, 10'h3f5);
        run(16'h39a5, 10'h020, 1'h1, jra);
        run(16'h39ad, 10'h020, 1'h1, jrb);
        // Not a jump: must fall through, and the step wraps at the top of code RAM
        run(16'hffff, 10'h3ff, 1'h0, 10'h000, 1'h0);
    endtask
    task automatic t_flags();
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_sys);
            flags <= ~(16'h0001 << i);
            run({5'h00, 6'(i), 5'h03}, 10'h100, 1'h1, 10'h103);
            run({5'h07, 1'h0, 6'(i), 4'h8}, 10'h100, 1'h1, jrb);
            run({5'h07, 1'h0, 6'(16 + i), 4'h0}, 10'h100, 1'h0, jra);
        end
    endtask
    task automatic t_tc_alu();
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            tcnt <= 4'h1 << i;
            alu <= i[0];
            run({5'h00, 6'(32 + i), 5'h1e}, 10'h040, 1'h1, 10'h03e);
            run({5'h00, 6'(32 + (i ^ 1)), 5'h1e}, 10'h040, 1'h0, 10'h03e);
            run({5'h00, 6'h2f, 5'h04}, 10'h040, i[0], 10'h044);
        end
    endtask
    function automatic logic pin_exp(input logic [5:0] c);
        logic [2:0] s;
        s = cfg ? want.cur6_fb : want.cur5_fb;
        case (c)
            6'h24: return !want.start;
            6'h25: return want.start;
            6'h26, 6'h27, 6'h28: return !want.shortcut_drain[c - 6'h26];
            6'h29, 6'h2a, 6'h2b: return !want.shortcut_source[c - 6'h29];
            6'h2c, 6'h2d, 6'h2e: return want.shortcut_drain[c - 6'h2c];
            6'h30: return want.boost_voltage_high;
            6'h31: return !want.boost_voltage_high;
            6'h32, 6'h33, 6'h34: return want.cur_fb[c - 6'h32];
            6'h35, 6'h36, 6'h37: return s[c - 6'h35];
            6'h38, 6'h39, 6'h3a: return !want.cur_fb[c - 6'h38];
            6'h3b, 6'h3c, 6'h3d: return !s[c - 6'h3b];
            6'h3e: return want.own_cur_fb;
            default: return !want.own_cur_fb;
        endcase
    endfunction
    task automatic t_pins(input mjump_pkg::mjump_pin_s p, input logic sel);
        @(posedge clk_sys);
        want <= p;
        cfg <= sel;
        // Pins cross two synchroniser stages and the source register
        repeat (4) @(posedge clk_sys);
        for (int c = 36; c < 64; c++) begin
            if (c != 47) run({5'h00, 6'(c), 5'h07}, 10'h200, pin_exp(6'(c)), 10'h207);
        end
        @(posedge clk_sys);
        c4 <= 1'h1;
        flags <= 16'h0000;
        run({5'h00, 6'h1c, 5'h07}, 10'h200, want.current_channel_four_high, 10'h207);
        run({5'h00, 6'h0c, 5'h07}, 10'h200, !want.current_channel_four_high, 10'h207);
        @(posedge clk_sys);
        c4 <= 1'h0;
    endtask
    task automatic t_fbk();
        @(posedge clk_sys);
        want.predriver_fb <= 16'h5a3c;
        repeat (4) @(posedge clk_sys);
        for (int s = 0; s < 32; s++) begin
            run({6'h05, 5'(s), 5'h11}, 10'h008, want.predriver_fb[s[3:0]] == s[4], 10'h3f9);
        end
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            test_done();
        end
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        nrst <= 1'h1;
        t_uncond();
        t_flags();
        t_tc_alu();
        t_pins(35'h2_a9b5_3c6d, 1'h0);
        t_pins(35'h5_564a_c392, 1'h1);
        t_fbk();
        test_done();
    end
endmodule
